// ===== logic/scc_config_commands.sv
// Notes on behaviour
// - save stores only configuration words
// - failed save sets memory error, alert
// - save in progress blocks bus, monitoring
// - save/reload act on code alone
// - reload copies stored configuration into working
// - reload runs automatically after every reset
// - feature report fixed bits read zero
// - feature bit four mirrors alert enable
// - data format report always 40h
// - data format write sets memory error
// - raise target applies on fresh command
// - lower target applies on fresh command
// - margin failure sets flags, keeps retrying
// - word commands carry two data bytes
// - monitor scale stored as ratio code
// - bus voltages converted by monitor scale
// - current gain stored in 0.1 milliohm
// - run codes select margin high/low
`timescale 1ns/1ns
`default_nettype none
module scc_config_commands (
  input  wire logic        sys_clk,          // 20 MHz clock
  input  wire logic        sys_rst,          // synchronous, active high
  input  wire logic        cmdValid,         // one-cycle pulse: command from bus engine
  input  wire logic        cmdWrite,         // 1 write, 0 read
  input  wire logic [7:0]  cmdCode,          // command code after address
  input  wire logic [15:0] cmdData,          // data low byte first already paired
  input  wire logic        cmdWord,          // two data bytes were received
  output logic             cmdReady,         // high when bus commands are accepted
  output logic [15:0]      readData,         // answer to a read
  output logic             readValid,        // one-cycle answer pulse
  input  wire logic        alertEnable,      // alert enable from vendor mode setting
  input  wire logic        marginFail,       // margin loop cannot converge
  input  wire logic        clearFlags,       // clear of all status flags
  output logic             monitorHold,      // suspend supply monitoring
  output logic [1:0]       marginMode,       // active margin state
  output logic [15:0]      activeTarget,     // latched margin target
  output logic [15:0]      monitorScale,     // working monitor scale
  output logic [15:0]      currentGain,      // working current gain
  output logic [7:0]       statusByte,       // status byte
  output logic [15:0]      statusWord,       // status word
  output logic [7:0]       vendorFlags,      // vendor detail flags
  output logic             alertOut,         // alert level
  output logic             nvWrite,          // nonvolatile write strobe
  output logic [1:0]       nvAddr,           // nonvolatile slot index
  output logic [15:0]      nvWData,          // nonvolatile write data
  input  wire logic [15:0] nvRData,          // nonvolatile read data, same cycle
  input  wire logic        nvError           // write failed on this slot
);
  scc_pkg::scc_state_t s_r;                  // registered state
  scc_pkg::scc_state_t s_nxt;                // next state
  logic [15:0]         feature;              // feature report value

  // feature report: only alert bit can be set
  always_comb begin
    feature = 16'h0000;
    feature[scc_pkg::FEATURE_ALERT_BIT] = alertEnable;
  end

  // next-state logic
  always_comb begin
    s_nxt           = s_r;
    s_nxt.readValid = 1'b0;
    // margin failure flags; retries left to margin loop
    if (marginFail) begin
      s_nxt.statusByte[scc_pkg::STATUS_CATCHALL_BIT]  = 1'b1;
      s_nxt.statusWord[scc_pkg::STATUS_CATCHALL_BIT]  = 1'b1;
      s_nxt.statusWord[scc_pkg::WORD_VENDOR_BIT]      = 1'b1;
      s_nxt.vendorFlags[scc_pkg::VENDOR_MARGIN_BIT]   = 1'b1;
    end
    case (s_r.nvState)
      scc_pkg::SCC_IDLE: begin
        if (cmdValid && cmdWrite) begin
          case (cmdCode)
            scc_pkg::CMD_SAVE_CFG: begin
              s_nxt.nvState = scc_pkg::SCC_SAVE;
              s_nxt.nvIdx   = 2'h0;
            end
            scc_pkg::CMD_RELOAD_CFG: begin
              s_nxt.nvState = scc_pkg::SCC_LOAD;
              s_nxt.nvIdx   = 2'h0;
            end
            scc_pkg::CMD_DATA_FORMAT: begin
              s_nxt.statusByte[scc_pkg::COMM_DETAIL_FLAGS_BIT] = 1'b1;
              s_nxt.statusWord[scc_pkg::COMM_DETAIL_FLAGS_BIT] = 1'b1;
            end
            scc_pkg::CMD_RAISE_TARGET: if (cmdWord) s_nxt.cfg.raiseTarget = cmdData;
            scc_pkg::CMD_LOWER_TARGET: if (cmdWord) s_nxt.cfg.lowerTarget = cmdData;
            scc_pkg::CMD_MONITOR_SCALE: if (cmdWord) s_nxt.cfg.monitorScale = cmdData;
            scc_pkg::CMD_CURRENT_GAIN: if (cmdWord) s_nxt.cfg.currentGain = cmdData;
            scc_pkg::CMD_RUN_CONTROL: begin
              if (cmdData[7:0] == scc_pkg::RUN_HIGH_IGNORE || cmdData[7:0] == scc_pkg::RUN_HIGH_ACT) begin
                s_nxt.margin       = scc_pkg::SCC_MARGIN_HIGH;
                s_nxt.activeTarget = s_r.cfg.raiseTarget;
              end else if (cmdData[7:0] == scc_pkg::RUN_LOW_IGNORE || cmdData[7:0] == scc_pkg::RUN_LOW_ACT) begin
                s_nxt.margin       = scc_pkg::SCC_MARGIN_LOW;
                s_nxt.activeTarget = s_r.cfg.lowerTarget;
              end else begin
                s_nxt.margin = scc_pkg::SCC_MARGIN_OFF;
              end
            end
            default: ;  // other commands belong elsewhere
          endcase
        end else if (cmdValid) begin
          s_nxt.readValid = 1'b1;
          case (cmdCode)
            scc_pkg::CMD_FEATURE:       s_nxt.readData = feature;
            scc_pkg::CMD_DATA_FORMAT:   s_nxt.readData = {8'h00, scc_pkg::DATA_FORMAT_VALUE};
            scc_pkg::CMD_RAISE_TARGET:  s_nxt.readData = s_r.cfg.raiseTarget;
            scc_pkg::CMD_LOWER_TARGET:  s_nxt.readData = s_r.cfg.lowerTarget;
            scc_pkg::CMD_MONITOR_SCALE: s_nxt.readData = s_r.cfg.monitorScale;
            scc_pkg::CMD_CURRENT_GAIN:  s_nxt.readData = s_r.cfg.currentGain;
            default: begin
              s_nxt.readData  = 16'h0000;
              s_nxt.readValid = 1'b0;   // not this block's command
            end
          endcase
        end
      end
      scc_pkg::SCC_SAVE: begin
        // cmdValid is not looked at here: the bus stays deaf until idle
        // failed save: error bits only, detail flags untouched
        if (nvError) begin
          s_nxt.statusByte[scc_pkg::COMM_DETAIL_FLAGS_BIT] = 1'b1;
          s_nxt.statusWord[scc_pkg::COMM_DETAIL_FLAGS_BIT] = 1'b1;
        end
        s_nxt.nvIdx = s_r.nvIdx + 2'h1;
        if (s_r.nvIdx == 2'(scc_pkg::NV_SLOTS - 1)) s_nxt.nvState = scc_pkg::SCC_IDLE;
      end
      // load sequence also used after reset
      scc_pkg::SCC_LOAD: begin
        // commands also dropped while the reload runs
        case (s_r.nvIdx)
          2'(scc_pkg::SLOT_RAISE): s_nxt.cfg.raiseTarget  = nvRData;
          2'(scc_pkg::SLOT_LOWER): s_nxt.cfg.lowerTarget  = nvRData;
          2'(scc_pkg::SLOT_SCALE): s_nxt.cfg.monitorScale = nvRData;
          default:                 s_nxt.cfg.currentGain  = nvRData;
        endcase
        s_nxt.nvIdx = s_r.nvIdx + 2'h1;
        if (s_r.nvIdx == 2'(scc_pkg::NV_SLOTS - 1)) s_nxt.nvState = scc_pkg::SCC_IDLE;
      end
      default: s_nxt.nvState = scc_pkg::SCC_IDLE;
    endcase
    // clear drops every bit already set before this cycle; only bits newly set this cycle survive
    if (clearFlags) begin
      s_nxt.statusByte  = s_nxt.statusByte & ~s_r.statusByte;
      s_nxt.statusWord  = s_nxt.statusWord & ~s_r.statusWord;
      s_nxt.vendorFlags = s_nxt.vendorFlags & ~s_r.vendorFlags;
    end
  end

  // state register; reset starts the automatic reload
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_r              <= '0;
      s_r.cfg          <= {4{scc_pkg::RESET_WORD_VALUE}};
      s_r.nvState      <= scc_pkg::SCC_LOAD;
      s_r.margin       <= scc_pkg::SCC_MARGIN_OFF;
    end else begin
      s_r <= s_nxt;
    end
  end

  // nonvolatile port: save drives configuration words only
  always_comb begin
    case (s_r.nvIdx)
      2'(scc_pkg::SLOT_RAISE): nvWData = s_r.cfg.raiseTarget;
      2'(scc_pkg::SLOT_LOWER): nvWData = s_r.cfg.lowerTarget;
      2'(scc_pkg::SLOT_SCALE): nvWData = s_r.cfg.monitorScale;
      default:                 nvWData = s_r.cfg.currentGain;
    endcase
  end

  assign nvWrite      = (s_r.nvState == scc_pkg::SCC_SAVE);
  assign nvAddr       = s_r.nvIdx;
  // unresponsive and monitoring held while saving
  assign cmdReady     = (s_r.nvState == scc_pkg::SCC_IDLE);
  assign monitorHold  = (s_r.nvState == scc_pkg::SCC_SAVE);
  assign readData     = s_r.readData;
  assign readValid    = s_r.readValid;
  assign marginMode   = s_r.margin;
  assign activeTarget = s_r.activeTarget;
  // scale handed to monitor for bus-to-ADC conversion
  assign monitorScale = s_r.cfg.monitorScale;
  assign currentGain  = s_r.cfg.currentGain;
  assign statusByte   = s_r.statusByte;
  assign statusWord   = s_r.statusWord;
  assign vendorFlags  = s_r.vendorFlags;
  assign alertOut     = alertEnable && ((|s_r.statusByte) || (|s_r.vendorFlags));
endmodule // scc_config_commands
`default_nettype wire

// ===== logic/scc_pkg.sv
package scc_pkg;
  // command codes
  localparam logic [7:0] CMD_RUN_CONTROL   = 8'h01;
  localparam logic [7:0] CMD_SAVE_CFG      = 8'h11;
  localparam logic [7:0] CMD_RELOAD_CFG    = 8'h12;
  localparam logic [7:0] CMD_FEATURE       = 8'h19;
  localparam logic [7:0] CMD_DATA_FORMAT   = 8'h20;
  localparam logic [7:0] CMD_RAISE_TARGET  = 8'h25;
  localparam logic [7:0] CMD_LOWER_TARGET  = 8'h26;
  localparam logic [7:0] CMD_MONITOR_SCALE = 8'h2A;
  localparam logic [7:0] CMD_CURRENT_GAIN  = 8'h38;
  // run-control margin codes
  localparam logic [7:0] RUN_HIGH_IGNORE = 8'hA4;
  localparam logic [7:0] RUN_HIGH_ACT    = 8'hA8;
  localparam logic [7:0] RUN_LOW_IGNORE  = 8'h94;
  localparam logic [7:0] RUN_LOW_ACT     = 8'h98;
  // fixed report values
  localparam logic [7:0] DATA_FORMAT_VALUE = 8'h40;
  localparam int         FEATURE_ALERT_BIT = 4;
  // status bit positions
  localparam int COMM_DETAIL_FLAGS_BIT      = 1;
  localparam int STATUS_CATCHALL_BIT = 0;
  localparam int WORD_VENDOR_BIT     = 12;
  localparam int VENDOR_MARGIN_BIT   = 0;
  // default working values when nonvolatile array is blank
  localparam logic [15:0] RESET_WORD_VALUE = 16'h0000;
  // nonvolatile slot indexes
  localparam int NV_SLOTS   = 4;
  localparam int SLOT_RAISE = 0;
  localparam int SLOT_LOWER = 1;
  localparam int SLOT_SCALE = 2;
  localparam int SLOT_GAIN  = 3;

  // margin states of the supply
  typedef enum logic [1:0] {SCC_MARGIN_OFF, SCC_MARGIN_HIGH, SCC_MARGIN_LOW} scc_margin_t;
  // nonvolatile sequencer states
  typedef enum logic [1:0] {SCC_IDLE, SCC_SAVE, SCC_LOAD} scc_nvstate_t;

  // configuration words held in working registers
  typedef struct packed {
    logic [15:0] raiseTarget;
    logic [15:0] lowerTarget;
    logic [15:0] monitorScale;
    logic [15:0] currentGain;
  } scc_cfg_t;

  // whole block state
  typedef struct packed {
    scc_cfg_t     cfg;
    scc_nvstate_t nvState;
    logic [1:0]   nvIdx;
    scc_margin_t  margin;
    logic [15:0]  activeTarget;
    logic [7:0]   statusByte;
    logic [15:0]  statusWord;
    logic [7:0]   vendorFlags;
    logic [15:0]  readData;
    logic         readValid;
  } scc_state_t;
endpackage : scc_pkg

// ===== verif/scc_config_commands_chk.sv
`timescale 1ns/1ns
`default_nettype none
module scc_config_commands_chk (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        cmdValid,
  input wire logic        cmdWrite,
  input wire logic [7:0]  cmdCode,
  input wire logic [15:0] cmdData,
  input wire logic        cmdReady,
  input wire logic [15:0] readData,
  input wire logic        readValid,
  input wire logic        alertEnable,
  input wire logic        marginFail,
  input wire logic        monitorHold,
  input wire logic [1:0]  marginMode,
  input wire logic [7:0]  statusByte,
  input wire logic [15:0] statusWord,
  input wire logic [7:0]  vendorFlags,
  input wire logic        alertOut,
  input wire logic        nvWrite,
  input wire logic [1:0]  nvAddr,
  input wire logic        nvError
);
  wire taken = cmdValid && cmdReady;  // command accepted at this edge
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_save_start: assert property (taken && cmdWrite && cmdCode == 8'h11 |=> nvWrite && nvAddr == 2'h0)
    else $error("save did not start at slot zero");
  a_save_span: assert property ($rose(nvWrite) |-> nvWrite [*4] ##1 !nvWrite)
    else $error("save length wrong");
  a_busy_deaf: assert property (nvWrite |-> !cmdReady && monitorHold)
    else $error("bus open or monitoring on during save");
  a_fmt_read: assert property (taken && !cmdWrite && cmdCode == 8'h20 |=> readValid && readData == 16'h0040)
    else $error("data format read wrong");
  a_feat_read: assert property (taken && !cmdWrite && cmdCode == 8'h19 |=> readValid &&
    readData[7:0] == {3'h0, $past(alertEnable), 4'h0}) else $error("feature read wrong");
  a_fmt_write: assert property (taken && cmdWrite && cmdCode == 8'h20 |=> statusByte[1] && statusWord[1])
    else $error("format write flag missing");
  a_save_fail: assert property (nvWrite && nvError |=> statusByte[1] && statusWord[1])
    else $error("failed save flag missing");
  a_margin_flag: assert property (marginFail |=> statusByte[0] && statusWord[0] && statusWord[12] && vendorFlags[0])
    else $error("margin failure flags missing");
  a_alert_map: assert property (alertOut == (alertEnable && (|statusByte || |vendorFlags)))
    else $error("alert level wrong");
  a_run_high: assert property (taken && cmdWrite && cmdCode == 8'h01 && cmdData[7:0] inside {8'hA4, 8'hA8}
    |=> marginMode == 2'h1) else $error("margin high not selected");
  c_save: cover property (taken && cmdCode == 8'h11);
  c_fail: cover property (nvError);
  c_feat: cover property (taken && cmdCode == 8'h19 && alertEnable);
endmodule // scc_config_commands_chk
`default_nettype wire

// ===== verif/scc_nv_model.sv
`timescale 1ns/1ns
`default_nettype none
// nonvolatile array behind the block, with write-failure injection
module scc_nv_model (
  input  wire logic        sys_clk,  // block clock
  input  wire logic        nvWrite,  // write strobe
  input  wire logic [1:0]  nvAddr,   // slot index
  input  wire logic [15:0] nvWData,  // word to store
  input  wire logic        failOn,   // bench asks for a failed write
  output logic [15:0]      nvRData,  // same-cycle read
  output logic             nvError   // write failed
);
  logic [15:0] mem [4];  // stored defaults, 1000h plus slot
  initial for (int i = 0; i < 4; i++) mem[i] = 16'h1000 + 16'(i);
  always @(posedge sys_clk) begin
    if (nvWrite && !failOn) mem[nvAddr] <= nvWData;
  end
  assign nvRData = mem[nvAddr];
  assign nvError = nvWrite && failOn;
endmodule // scc_nv_model
`default_nettype wire

// ===== verif/tb_supply_manager_config_commands.sv
`timescale 1ns/1ns
`default_nettype none
module tb_supply_manager_config_commands;
  logic        sys_clk = 1'h0, sys_rst = 1'h1, cmdValid = 1'h0, cmdWrite = 1'h0, cmdWord = 1'h0;
  logic        alertEnable = 1'h0, marginFail = 1'h0, clearFlags = 1'h0, failOn = 1'h0;
  logic [7:0]  cmdCode = 8'h00;
  logic [15:0] cmdData = 16'h0000;
  logic        cmdReady, readValid, monitorHold, alertOut, nvWrite, nvError;
  logic [1:0]  marginMode, nvAddr;
  logic [15:0] readData, activeTarget, monitorScale, currentGain, statusWord, nvWData, nvRData;
  logic [7:0]  statusByte, vendorFlags;
  logic [15:0] w [4];  // expected working words
  logic [7:0]  wc [4] = '{8'h25, 8'h26, 8'h2A, 8'h38};
  logic [7:0]  rc [4] = '{8'hA4, 8'hA8, 8'h94, 8'h98};
  int          n_errors = 0, checks_done = 0;
  always #25 sys_clk = ~sys_clk;
  scc_config_commands scc_config_commands_inst (.sys_clk, .sys_rst, .cmdValid, .cmdWrite, .cmdCode, .cmdData,
    .cmdWord, .cmdReady, .readData, .readValid, .alertEnable, .marginFail, .clearFlags, .monitorHold, .marginMode,
    .activeTarget, .monitorScale, .currentGain, .statusByte, .statusWord, .vendorFlags, .alertOut, .nvWrite,
    .nvAddr, .nvWData, .nvRData, .nvError);
  scc_nv_model scc_nv_model_inst (.sys_clk, .nvWrite, .nvAddr, .nvWData, .failOn, .nvRData, .nvError);
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one command, held for one edge, outputs settled after
  task automatic cmd(input logic wr, input logic [7:0] code, input logic [15:0] d);
    @(posedge sys_clk);
    cmdValid <= 1'h1;
    cmdWrite <= wr;
    cmdWord <= wr;
    cmdCode <= code;
    cmdData <= d;
    @(posedge sys_clk);
    cmdValid <= 1'h0;
    #1;
  endtask
  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
    cmd(1'h0, code, 16'h0000);
    chk("readValid", {15'h0, readValid}, 16'h0001);
    chk("readData", readData, exp);
  endtask
  // bounded wait for the nonvolatile sequencer
  task automatic idle();
    for (int i = 0; i < 20 && cmdReady !== 1'h1; i++) @(posedge sys_clk);
    #1;
  endtask
  task automatic test_done();
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    logic [15:0] v;
    v = 16'($urandom(32'hE864));
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'h0;
    idle();
    chk("monitorScale", monitorScale, 16'h1002);
    chk("currentGain", currentGain, 16'h1003);
    for (int i = 0; i < 4; i++) begin
      w[i] = (i == 0) ? 16'hFFFF : 16'($urandom);
      cmd(1'h1, wc[i], w[i]);
    end
    chk("monitorScale", monitorScale, w[2]);
    chk("currentGain", currentGain, w[3]);
    for (int i = 0; i < 4; i++) rd(wc[i], w[i]);
    for (int i = 0; i < 4; i++) begin
      cmd(1'h1, 8'h01, {8'h00, rc[i]});
      chk("marginMode", {14'h0, marginMode}, (i < 2) ? 16'h0001 : 16'h0002);
      chk("activeTarget", activeTarget, (i < 2) ? w[0] : w[1]);
    end
    cmd(1'h1, 8'h26, v);
    chk("activeTarget", activeTarget, w[1]);
    w[1] = v;
    cmd(1'h1, 8'h01, 16'h0098);
    chk("activeTarget", activeTarget, w[1]);
    for (int i = 0; i < 2; i++) begin
      alertEnable <= i[0];
      rd(8'h19, {11'h0, i[0], 4'h0});
    end
    rd(8'h20, 16'h0040);
    cmd(1'h1, 8'h20, v);
    chk("formatWriteFlag", {15'h0, statusByte[1]}, 16'h0001);
    chk("alertOut", {15'h0, alertOut}, 16'h0001);
    clearFlags <= 1'h1;
    @(posedge sys_clk);
    clearFlags <= 1'h0;
    // save issued with margin low still selected, with a zero data word
    cmd(1'h1, 8'h11, 16'h0000);
    chk("monitorHold", {15'h0, monitorHold}, 16'h0001);
    chk("cmdReady", {15'h0, cmdReady}, 16'h0000);
    cmd(1'h1, 8'h25, 16'h1234);
    idle();
    for (int i = 0; i < 4; i++) chk("storedWord", scc_nv_model_inst.mem[i], w[i]);
    rd(8'h25, w[0]);
    chk("statusByte", {8'h00, statusByte}, 16'h0000);
    failOn <= 1'h1;
    cmd(1'h1, 8'h11, 16'h0000);
    idle();
    failOn <= 1'h0;
    chk("saveFailFlags", {14'h0, statusByte[1], statusWord[1]}, 16'h0003);
    // host scale word written as a plain ratio code
    cmd(1'h1, 8'h2A, ~w[2]);
    cmd(1'h1, 8'h12, 16'h0000);
    idle();
    chk("monitorScale", monitorScale, w[2]);
    marginFail <= 1'h1;
    @(posedge sys_clk);
    marginFail <= 1'h0;
    #1;
    chk("marginFlags", {12'h0, statusByte[0], statusWord[0], statusWord[12], vendorFlags[0]}, 16'h000F);
    test_done();
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    test_done();
  end
endmodule // tb_supply_manager_config_commands
bind scc_config_commands scc_config_commands_chk scc_config_commands_chk_inst (.sys_clk, .sys_rst, .cmdValid,
  .cmdWrite, .cmdCode, .cmdData, .cmdReady, .readData, .readValid, .alertEnable, .marginFail, .monitorHold,
  .marginMode, .statusByte, .statusWord, .vendorFlags, .alertOut, .nvWrite, .nvAddr, .nvError);
`default_nettype wire
